/* File: logic/reset_source_control.sv */
// Notes on behaviour
// - Pin, watchdog timeout or software request each start a warm reset.
// - Pin low for at least 12 system clocks is a valid reset.
// - Warm reset returns core control registers to reset values.
// - Flag, security and debug registers return to reset values only on cold reset.
// - PLL is off after reset until software enables it.
// - After exception sequence the core branches to reset service routine.
// - RAM contents are not guaranteed across a reset.
`timescale 1ns/1ps
`include "rsc_params.svh"

module reset_source_control
	import rsc_pkg::*;
#(
	parameter int HOLD_CYCLES = `RSC_HOLD_CYCLES,
	parameter int EXC_CYCLES  = `RSC_EXC_CYCLES
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_ext_rst_n,
	input  wire logic                   i_wdt_timeout,
	input  wire logic [`RSC_ADDR_W-1:0] i_addr,
	input  wire logic [`RSC_DATA_W-1:0] i_wr_data,
	input  wire logic                   i_wr_en,
	input  wire logic                   i_rd_en,
	output logic      [`RSC_DATA_W-1:0] o_rd_data,
	output logic                        o_warm_rst_n,
	output logic                        o_pll_enable,
	output logic                        o_branch_reset_handler,
	output logic                        o_debug_rst_n
);

	seq_state_t             state;
	seq_state_t             next_state;
	logic [`RSC_CNT_W-1:0]  cnt;
	flag_t                  flags;
	logic [`RSC_SEC_W-1:0]  security;
	logic                   pll_sel;
	logic                   pin_req;

	////////////////////////////////////////////////////////////////////////
	reset_pin_filter #(
		.MIN_LOW     (`RSC_PIN_MIN_CYCLES)
	) u_pin (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_pin_rst_n (i_ext_rst_n),
		.o_reset     (pin_req)
	);

	////////////////////////////////////////////////////////////////////////
	// Register writes only while the core runs; ignored in hold and during the exception sequence
	wire logic run    = (state == ST_RUN);
	wire logic wr_ok  = i_wr_en && run;
	wire logic wr_flg = wr_ok && (i_addr == `RSC_OFF_FLAG);
	wire logic wr_sec = wr_ok && (i_addr == `RSC_OFF_SECURITY);
	wire logic wr_pll = wr_ok && (i_addr == `RSC_OFF_PLLSEL);
	wire logic sw_req = wr_ok && (i_addr == `RSC_OFF_SWRST)
		&& i_wr_data[`RSC_SWRST_REQ_BIT];
	wire logic any_req = pin_req || i_wdt_timeout || sw_req;

	wire logic hold_done = (cnt == `RSC_CNT_W'(HOLD_CYCLES - 1));
	wire logic exc_done  = (cnt == `RSC_CNT_W'(EXC_CYCLES - 1));
	// Stop at the end of the current phase; a long pin or watchdog
	// assertion would otherwise run the count past the end of hold
	wire logic cnt_stop  = (state == ST_HOLD) ? hold_done : exc_done;

	wire flag_t flag_set = {sw_req, i_wdt_timeout, pin_req, 1'b0};
	wire flag_t flag_clr = wr_flg ? i_wr_data[`RSC_FLAG_W-1:0] : '0;
	// Set wins over a write-one-to-clear in the same cycle
	wire flag_t next_flags = (flags & ~flag_clr) | flag_set;

	// Warm reset forces the PLL off; only a later write turns it on
	wire logic next_pll = (next_state == ST_HOLD) ? `RSC_PLLSEL_RESET :
		(wr_pll ? i_wr_data[`RSC_PLLSEL_EN_BIT] : pll_sel);

	wire logic [`RSC_DATA_W-1:0] rd_mux =
		(i_addr == `RSC_OFF_FLAG)     ? `RSC_DATA_W'(flags)    :
		(i_addr == `RSC_OFF_SECURITY) ? `RSC_DATA_W'(security) :
		(i_addr == `RSC_OFF_PLLSEL)   ? `RSC_DATA_W'(pll_sel)  :
		(i_addr == `RSC_OFF_STATUS)   ? `RSC_DATA_W'({pll_sel, run}) :
		'0;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_RUN:
				if (any_req)
					next_state = ST_HOLD;
			ST_HOLD:
				// Stretch while a pin or watchdog source still asserts
				if (hold_done && !pin_req && !i_wdt_timeout)
					next_state = ST_EXC;
			ST_EXC:
				if (pin_req || i_wdt_timeout)
					next_state = ST_HOLD;
				else if (exc_done)
					next_state = ST_RUN;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Cold reset starts in hold so the core also sees the exception sequence
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state <= ST_HOLD;
			cnt   <= '0;
		end
		else
		begin
			state <= next_state;
			cnt   <= (next_state != state) ? '0 :
				(cnt_stop ? cnt : cnt + `RSC_CNT_W'(1));
		end
	end

	// Only the cold reset loads reset values into these
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			flags         <= `RSC_FLAG_RESET;
			security      <= `RSC_SEC_RESET;
			o_debug_rst_n <= 1'b0;
		end
		else
		begin
			flags         <= next_flags;
			security      <= wr_sec ? i_wr_data[`RSC_SEC_W-1:0] : security;
			o_debug_rst_n <= 1'b1;
		end
	end

	// RAM is given no retention; the core reset alone is driven
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pll_sel                <= `RSC_PLLSEL_RESET;
			o_pll_enable           <= 1'b0;
			o_warm_rst_n           <= 1'b0;
			o_branch_reset_handler <= 1'b0;
			o_rd_data              <= '0;
		end
		else
		begin
			pll_sel                <= next_pll;
			o_pll_enable           <= next_pll;
			o_warm_rst_n           <= (next_state != ST_HOLD);
			o_branch_reset_handler <= (state == ST_EXC)
				&& (next_state == ST_RUN);
			o_rd_data              <= i_rd_en ? rd_mux : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_wdt_reset;
		@(posedge i_clk) disable iff (!i_rst_n)
		(run && i_wdt_timeout) |=> !o_warm_rst_n;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset)
		else $error("Watchdog timeout did not reset the core");

	property p_pin_merge;
		@(posedge i_clk) disable iff (!i_rst_n)
		pin_req |=> !o_warm_rst_n && flags[`RSC_FLAG_PIN];
	endproperty
	a_pin_merge: assert property (p_pin_merge)
		else $error("Pin reset not merged into warm reset");

	property p_hold_len;
		@(posedge i_clk) disable iff (!i_rst_n)
		$fell(o_warm_rst_n) |-> (!o_warm_rst_n)[*4];
	endproperty
	a_hold_len: assert property (p_hold_len)
		else $error("Warm reset shorter than the hold time");

	property p_cold_only;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_HOLD) |=> $stable(security) && o_debug_rst_n;
	endproperty
	a_cold_only: assert property (p_cold_only)
		else $error("Cold-only state changed during warm reset");

	property p_pll_off;
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(o_warm_rst_n) |-> !o_pll_enable;
	endproperty
	a_pll_off: assert property (p_pll_off)
		else $error("PLL enabled on leaving reset");

	property p_branch;
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(o_warm_rst_n) ##1 (!pin_req && !i_wdt_timeout)[*7]
			|=> o_branch_reset_handler;
	endproperty
	a_branch: assert property (p_branch)
		else $error("No branch after the exception sequence");

	property p_read_late;
		@(posedge i_clk) disable iff (!i_rst_n)
		!i_rd_en |=> (o_rd_data == '0);
	endproperty
	a_read_late: assert property (p_read_late)
		else $error("Read data outside the cycle after a read");

	c_pin_reset: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		run && pin_req);
	c_wdt_reset: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		run && i_wdt_timeout);
	c_sw_reset: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		sw_req ##[1:20] o_branch_reset_handler);
	c_pll_on: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(o_pll_enable));

endmodule

/* File: logic/rsc_params.svh */
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

`define RSC_ADDR_W          8
`define RSC_DATA_W          32

`define RSC_OFF_FLAG        8'h00
`define RSC_OFF_SECURITY    8'h04
`define RSC_OFF_PLLSEL      8'h08
`define RSC_OFF_SWRST       8'h0C
`define RSC_OFF_STATUS      8'h10

`define RSC_FLAG_W          4
`define RSC_FLAG_POR        0
`define RSC_FLAG_PIN        1
`define RSC_FLAG_WDT        2
`define RSC_FLAG_SW         3
`define RSC_FLAG_RESET      4'h1

`define RSC_SEC_W           8
`define RSC_SEC_RESET       8'h00
`define RSC_PLLSEL_EN_BIT   0
`define RSC_PLLSEL_RESET    1'h0
`define RSC_SWRST_REQ_BIT   1
`define RSC_STAT_RUN_BIT    0
`define RSC_STAT_PLL_BIT    1

`define RSC_PIN_MIN_CYCLES  12
`define RSC_HOLD_CYCLES     4
`define RSC_EXC_CYCLES      8
`define RSC_CNT_W           4

`endif

/* File: logic/rsc_pkg.sv */
`include "rsc_params.svh"

package rsc_pkg;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_HOLD,
		ST_EXC
	} seq_state_t;

	typedef logic [`RSC_FLAG_W-1:0] flag_t;

endpackage

/* File: logic/reset_pin_filter.sv */
`timescale 1ns/1ps
`include "rsc_params.svh"

module reset_pin_filter #(
	parameter int MIN_LOW = `RSC_PIN_MIN_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_pin_rst_n,
	output logic      o_reset
);

	logic                  pin_meta;
	logic                  pin_s;
	logic [`RSC_CNT_W-1:0] low_cnt;

	wire logic                  cnt_full = (low_cnt >= `RSC_CNT_W'(MIN_LOW - 1));
	wire logic [`RSC_CNT_W-1:0] next_cnt = pin_s ? '0 :
		(cnt_full ? low_cnt : low_cnt + `RSC_CNT_W'(1));

	////////////////////////////////////////////////////////////////////////
	// Pin is asynchronous to the system clock
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pin_meta <= 1'b1;
			pin_s    <= 1'b1;
			low_cnt  <= '0;
			o_reset  <= 1'b0;
		end
		else
		begin
			pin_meta <= i_pin_rst_n;
			pin_s    <= pin_meta;
			low_cnt  <= next_cnt;
			// Short glitches never reach the core
			o_reset  <= !pin_s && cnt_full;
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_pin_min_low;
		@(posedge i_clk) disable iff (!i_rst_n)
		($fell(pin_s) ##1 (!pin_s)[*5] ##1 (!pin_s)[*6]) |=> o_reset;
	endproperty
	a_pin_min_low: assert property (p_pin_min_low)
		else $error("Pin low 12 cycles not taken as reset");

	property p_pin_short;
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(o_reset) |-> $past(!pin_s, 12);
	endproperty
	a_pin_short: assert property (p_pin_short)
		else $error("Reset taken from a pulse shorter than 12 cycles");

endmodule

/* File: testbench/board_supervisor.sv */
`timescale 1ns/1ps
module board_supervisor #(
	parameter int COLD_HOLD = 2
) (
	input  wire logic       i_clk,
	input  wire logic       i_por_n,
	input  wire logic       i_req,
	input  wire logic [7:0] i_len,
	output logic            o_pin_rst_n
);
	logic [7:0] low_left;
	////////////////////////////////////////////////////////////////////////
	// Pin low through power-up; settle time cut to COLD_HOLD to stay short
	always_ff @(posedge i_clk or negedge i_por_n)
	begin
		if (!i_por_n)
			low_left <= 8'(COLD_HOLD);
		else if (i_req)
			low_left <= i_len;
		else if (low_left != 8'h00)
			low_left <= low_left - 8'h01;
	end
	// Released pin sits at its pull-up level
	assign o_pin_rst_n = (low_left == 8'h00);
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`include "rsc_params.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
	logic        i_clk, i_rst_n, i_wdt_timeout, i_wr_en, i_rd_en;
	logic [7:0]  i_addr, sv_len;
	logic [31:0] i_wr_data, o_rd_data;
	logic        o_warm_rst_n, o_pll_enable, o_branch_reset_handler;
	logic        o_debug_rst_n, pin_n, sv_req;
	int          err_count, total_checks, n, m_flag, m_sec;
	logic [15:0] lfsr;
	reset_source_control dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_ext_rst_n(pin_n), .i_wdt_timeout(i_wdt_timeout),
		.i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
		.i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
		.o_warm_rst_n(o_warm_rst_n), .o_pll_enable(o_pll_enable),
		.o_branch_reset_handler(o_branch_reset_handler),
		.o_debug_rst_n(o_debug_rst_n));
	board_supervisor sup (.i_clk(i_clk), .i_por_n(i_rst_n), .i_req(sv_req),
		.i_len(sv_len), .o_pin_rst_n(pin_n));
	////////////////////////////////////////////////////////////////////////
	function logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task report_and_stop;
		if (err_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wr_data <= d;
		i_wr_en <= 1'b1;
		@(posedge i_clk);
		i_wr_en <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd_en <= 1'b1;
		@(posedge i_clk);
		i_rd_en <= 1'b0;
		#1 `CHK(o_rd_data, e)
	endtask
	// Bounded wait for the branch pulse; n counts edges waited
	task wait_br;
		for (n = 0; o_branch_reset_handler !== 1'b1; n++)
		begin
			if (n > 300)
			begin
				err_count++;
				$display("[ERR] %0t no branch pulse", $time);
				report_and_stop();
			end
			@(posedge i_clk);
			#1;
		end
	endtask
	task after_warm;
		`CHK(o_warm_rst_n, 1'b0)
		for (n = 1; o_warm_rst_n !== 1'b1 && n < 60; n++)
			@(posedge i_clk) #1;
		`CHK(n, 1 + `RSC_HOLD_CYCLES)
		wait_br();
		`CHK(n, `RSC_EXC_CYCLES)
	endtask
	task regs_chk;
		`CHK(o_debug_rst_n, 1'b1)
		`CHK(o_pll_enable, 1'b0)
		rd_chk(`RSC_OFF_FLAG, 32'(m_flag));
		rd_chk(`RSC_OFF_SECURITY, 32'(m_sec));
		rd_chk(`RSC_OFF_PLLSEL, 32'h0);
	endtask
	task cold;
		i_rst_n <= 1'b0;
		repeat (1) @(posedge i_clk);
		#1 `CHK(o_debug_rst_n, 1'b0)
		`CHK(o_warm_rst_n, 1'b0)
		@(posedge i_clk) i_rst_n <= 1'b1;
		wait_br();
		m_flag = 1;
		m_sec = 0;
		regs_chk();
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	initial
	begin
		{i_rst_n, i_wdt_timeout, i_wr_en, i_rd_en, sv_req} = 5'h00;
		{i_addr, sv_len, i_wr_data} = 48'h0;
		{err_count, total_checks, m_flag, m_sec} = 0;
		lfsr = 16'h56CF;
		cold();
		@(posedge i_clk) {sv_req, sv_len} <= {1'b1, 8'h0B};
		@(posedge i_clk) sv_req <= 1'b0;
		for (n = 0; n < 30 && o_warm_rst_n === 1'b1; n++)
			@(posedge i_clk) #1;
		`CHK(n, 30)
		for (int k = 0; k < 4; k++)
		begin
			lfsr = lfsr_next(lfsr);
			m_sec = int'(lfsr[7:0]);
			wr_reg(`RSC_OFF_SECURITY, {24'h0, lfsr[7:0]});
			wr_reg(`RSC_OFF_PLLSEL, 32'h1);
			#1 `CHK(o_pll_enable, 1'b1)
			rd_chk(`RSC_OFF_STATUS, 32'h3);
			rd_chk(8'h20, 32'h0);
			if (k == 0)
			begin
				@(posedge i_clk) i_wdt_timeout <= 1'b1;
				@(posedge i_clk) i_wdt_timeout <= 1'b0;
				#1 after_warm();
				m_flag |= 4;
			end
			else if (k == 1)
			begin
				// Normal clock mode here, so a software request is legal
				wr_reg(`RSC_OFF_SWRST, 32'h2);
				#1 after_warm();
				m_flag |= 8;
			end
			else
			begin
				// Exactly the minimum first, then a long hold that stretches
				@(posedge i_clk) {sv_req, sv_len} <=
					{1'b1, ((k == 2) ? 8'h0C : 8'h28)};
				@(posedge i_clk) sv_req <= 1'b0;
				wait_br();
				m_flag |= 2;
			end
			regs_chk();
		end
		wr_reg(`RSC_OFF_FLAG, 32'hF);
		rd_chk(`RSC_OFF_FLAG, 32'h0);
		cold();
		report_and_stop();
	end
endmodule
